/* verilog/fau_pkg.sv */
// Shared constants, field layouts and float helpers for the float abs/add unit.
// Assumes a 32-bit APB register bus and IEEE single-precision operands.
package fau_pkg;

    // Register byte offsets.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_SRC1 = 8'h00;
    localparam logic [7:0] ADDR_SRC2 = 8'h04;
    localparam logic [7:0] ADDR_GUARD = 8'h08;
    localparam logic [7:0] ADDR_ISSUE = 8'h0c;
    localparam logic [7:0] ADDR_DEST = 8'h10;
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h14;
    localparam logic [7:0] ADDR_UNIT_STATUS = 8'h18;

    // Operation codes and issue slots.
    localparam logic [7:0] OPC_ABS = 8'h73;
    localparam logic [7:0] OPC_ABS_FLAGS = 8'h74;
    localparam logic [7:0] OPC_ADD = 8'h16;
    localparam logic [2:0] SLOT_A = 3'h1;
    localparam logic [2:0] SLOT_B = 3'h4;
    localparam int LATENCY = 3;

    // Issue word fields.
    localparam int ISS_OPC_LSB = 0;
    localparam int ISS_SLOT_LSB = 8;
    localparam int ISS_GUARD_BIT = 12;

    // Exception vector layout, shared by the status word and flag results.
    localparam int FLAG_W = 7;
    localparam int FLG_DBZ = 0;
    localparam int FLG_INX = 1;
    localparam int FLG_UNF = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_INV = 4;
    localparam int FLG_IFZ = 5;
    localparam int FLG_OFZ = 6;

    // Status word rounding field and unit status bits.
    localparam int SW_RM_LSB = 8;
    localparam int US_BUSY_BIT = 0;
    localparam int US_REJECT_BIT = 1;

    // Float format.
    localparam logic [31:0] QNAN = 32'hffff_ffff;
    localparam logic [7:0] EXP_MAX = 8'hff;

    typedef enum logic [1:0] {RM_NEAREST, RM_ZERO, RM_POS, RM_NEG} fau_rmode_t;

    function automatic logic is_denorm(input logic [31:0] x);
        return (x[30:23] == 8'h00) && (x[22:0] != 23'h00_0000);
    endfunction

    function automatic logic is_nan(input logic [31:0] x);
        return (x[30:23] == EXP_MAX) && (x[22:0] != 23'h00_0000);
    endfunction

    function automatic logic is_snan(input logic [31:0] x);
        return is_nan(x) && !x[22];
    endfunction

    function automatic logic is_inf(input logic [31:0] x);
        return (x[30:23] == EXP_MAX) && (x[22:0] == 23'h00_0000);
    endfunction

endpackage

/* verilog/fau_adder.sv */
// Combinational single-precision adder with flush-to-zero on input and output.
// Assumes the caller registers the sum; the path is long and meant to be pipelined.
`timescale 1ns/1ps
`default_nettype none
module fau_adder (
    // Operands and rounding mode
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic [1:0] rmode,
    // Result
    output logic [31:0] sum,
    output logic [fau_pkg::FLAG_W-1:0] flags
);
    logic [31:0] fa;
    logic [31:0] fb;
    logic [31:0] big;
    logic [31:0] lesser;
    logic [26:0] m_big;
    logic [26:0] m_al;
    logic [53:0] wide;
    logic [7:0] d;
    logic [27:0] s;
    logic [27:0] n;
    logic [4:0] lz;
    logic found;
    logic signed [9:0] e;
    logic [24:0] mr;
    logic up;
    logic inexact;
    logic rs;
    logic same;

    always_comb begin
        fa = fau_pkg::is_denorm(op_a) ? {op_a[31], 31'h0000_0000} : op_a;
        fb = fau_pkg::is_denorm(op_b) ? {op_b[31], 31'h0000_0000} : op_b;
        flags = '0;
        flags[fau_pkg::FLG_IFZ] = fau_pkg::is_denorm(op_a) | fau_pkg::is_denorm(op_b);
        sum = 32'h0000_0000;
        big = (fb[30:0] > fa[30:0]) ? fb : fa;
        lesser = (fb[30:0] > fa[30:0]) ? fa : fb;
        same = fa[31] == fb[31];
        rs = big[31];
        m_big = {|big[30:23], big[22:0], 3'b000};
        d = big[30:23] - lesser[30:23];
        wide = {{|lesser[30:23], lesser[22:0], 3'b000}, 27'h000_0000} >> d;
        // Bits shifted out collapse into a sticky bit so subtraction still rounds right.
        // Past the shifter's reach every bit of the smaller operand belongs in the sticky bit.
        m_al = {wide[53:28], wide[27] | (|wide[26:0]) | ((d > 8'd26) && (|lesser[30:0]))};
        s = same ? {1'b0, m_big} + {1'b0, m_al} : {1'b0, m_big} - {1'b0, m_al};
        lz = 5'd0;
        found = 1'b0;
        for (int i = 26; i >= 0; i--) begin
            if (!found && !s[i]) begin
                lz = lz + 5'd1;
            end else begin
                found = 1'b1;
            end
        end
        e = $signed({2'b00, big[30:23]});
        if (s[27]) begin
            n = {1'b0, s[27:2], s[1] | s[0]};
            e = e + 10'sd1;
        end else begin
            n = s << lz;
            e = e - $signed({5'b00000, lz});
        end
        inexact = n[2] | n[1] | n[0];
        unique case (fau_pkg::fau_rmode_t'(rmode))
            fau_pkg::RM_NEAREST: up = n[2] & (n[1] | n[0] | n[3]);
            fau_pkg::RM_ZERO: up = 1'b0;
            fau_pkg::RM_POS: up = inexact & !rs;
            fau_pkg::RM_NEG: up = inexact & rs;
        endcase
        mr = {1'b0, n[26:3]} + {24'h00_0000, up};
        if (mr[24]) begin
            mr = mr >> 1;
            e = e + 10'sd1;
        end
        if (fau_pkg::is_nan(fa) || fau_pkg::is_nan(fb)) begin
            sum = fau_pkg::QNAN;
            flags[fau_pkg::FLG_INV] = fau_pkg::is_snan(fa) | fau_pkg::is_snan(fb);
        end else if (fau_pkg::is_inf(fa) || fau_pkg::is_inf(fb)) begin
            if (fau_pkg::is_inf(fa) && fau_pkg::is_inf(fb) && !same) begin
                sum = fau_pkg::QNAN;
                flags[fau_pkg::FLG_INV] = 1'b1;
            end else begin
                sum = big;
            end
        end else if (s == 28'h000_0000) begin
            sum = {same ? rs : (rmode == fau_pkg::RM_NEG), 31'h0000_0000};
        end else if (e >= $signed({2'b00, fau_pkg::EXP_MAX})) begin
            sum = {rs, fau_pkg::EXP_MAX, 23'h00_0000};
            flags[fau_pkg::FLG_OVF] = 1'b1;
            flags[fau_pkg::FLG_INX] = 1'b1;
        end else if (e <= 10'sd0) begin
            sum = {rs, 31'h0000_0000};
            flags[fau_pkg::FLG_OFZ] = 1'b1;
            flags[fau_pkg::FLG_UNF] = 1'b1;
            flags[fau_pkg::FLG_INX] = 1'b1;
        end else begin
            sum = {rs, e[7:0], mr[22:0]};
            flags[fau_pkg::FLG_INX] = inexact;
        end
    end
endmodule
`default_nettype wire

/* verilog/fau_top.sv */
// Float abs/add unit: APB registers, issue decode, fixed-latency pipeline, status word.
// Assumes other float units on the same clock report their flag updates on ext_flag_set.
//
// Operation
// - Absolute value clears sign except on NaN, flushes denormals.
// - Absolute value exceptions set status flags.
// - Flags sticky, cleared only by status write.
// - Flag update lands with destination write.
// - Simultaneous flag updates OR with old value.
// - Guard LSB zero blocks destination and flags when the issue sets the guard bit.
// - Flags-only abs writes flag vector to destination.
// - Flags-only abs leaves status flags alone.
// - Flags-only abs reports denormal as input flush.
// - Flags-only abs honours the guard too.
// - Flags-only abs: code 116, latency 3, slots 1/4.
// - Add: code 22, latency 3, slots 1/4.
// - Add rounds per status word rounding mode.
// - Add flushes denormal inputs, sets input flush.
// - Denormal sum becomes zero, sets output flush.
// - Add exceptions set matching status flags.
// - Flag vector bit layout, upper bits zero.
// - Absolute value: code 115, latency 3, slots 1/4.
`timescale 1ns/1ps
`default_nettype none
module fau_top #(
    parameter int LATENCY = fau_pkg::LATENCY
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fau_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flag updates from other float units retiring this cycle
    input wire logic [fau_pkg::FLAG_W-1:0] ext_flag_set,
    // Status towards the core
    output logic [fau_pkg::FLAG_W-1:0] status_flags,
    output logic result_strobe
);
    localparam int FW = fau_pkg::FLAG_W;

    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] guard_word;
    logic [31:0] issue_word;
    logic [31:0] dest;
    logic [FW-1:0] flag_reg;
    logic [1:0] rmode_reg;
    logic reject;
    logic [31:0] next_rdata;

    logic [LATENCY-1:0] pipe_valid;
    logic [LATENCY-1:0] pipe_wr;
    logic [LATENCY-1:0] pipe_setflags;
    logic [31:0] pipe_res [LATENCY];
    logic [FW-1:0] pipe_flags [LATENCY];

    logic setup;
    logic access_wr;
    logic addr_hit;
    logic issue_req;
    logic [7:0] opc;
    logic [2:0] slot;
    logic guard_present;
    logic guard_ok;
    logic slot_ok;
    logic op_legal;
    logic [31:0] new_issue;
    logic [31:0] abs_res;
    logic [FW-1:0] abs_flags;
    logic [31:0] add_sum;
    logic [FW-1:0] add_flags;
    logic [31:0] op_res;
    logic [FW-1:0] op_flags;
    logic op_setflags;
    logic retire;
    logic [FW-1:0] retire_flags;
    logic [FW-1:0] next_flags;
    logic [31:0] sw_write;

    // Byte-lane merge used by every writable register except the unit status.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // APB decode.
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        unique case (paddr)
            fau_pkg::ADDR_SRC1,
            fau_pkg::ADDR_SRC2,
            fau_pkg::ADDR_GUARD,
            fau_pkg::ADDR_ISSUE,
            fau_pkg::ADDR_DEST,
            fau_pkg::ADDR_STATUS_WORD,
            fau_pkg::ADDR_UNIT_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_hit;

    // Read data is latched in the setup cycle, so the zero-wait access phase sees a flop.
    always_comb begin
        unique case (paddr)
            fau_pkg::ADDR_SRC1: next_rdata = src1;
            fau_pkg::ADDR_SRC2: next_rdata = src2;
            fau_pkg::ADDR_GUARD: next_rdata = guard_word;
            fau_pkg::ADDR_ISSUE: next_rdata = issue_word;
            fau_pkg::ADDR_DEST: next_rdata = dest;
            fau_pkg::ADDR_STATUS_WORD: begin
                next_rdata = 32'h0000_0000;
                next_rdata[FW-1:0] = flag_reg;
                next_rdata[fau_pkg::SW_RM_LSB +: 2] = rmode_reg;
            end
            fau_pkg::ADDR_UNIT_STATUS: begin
                next_rdata = 32'h0000_0000;
                next_rdata[fau_pkg::US_BUSY_BIT] = |pipe_valid;
                next_rdata[fau_pkg::US_REJECT_BIT] = reject;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Operand and guard registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src1 <= 32'h0000_0000;
            src2 <= 32'h0000_0000;
            guard_word <= 32'h0000_0000;
        end else if (access_wr) begin
            if (paddr == fau_pkg::ADDR_SRC1) begin
                src1 <= merge(src1, pwdata, pstrb);
            end
            if (paddr == fau_pkg::ADDR_SRC2) begin
                src2 <= merge(src2, pwdata, pstrb);
            end
            if (paddr == fau_pkg::ADDR_GUARD) begin
                guard_word <= merge(guard_word, pwdata, pstrb);
            end
        end
    end

    // Issue decode: a write to the issue word launches one operation.
    assign issue_req = access_wr && (paddr == fau_pkg::ADDR_ISSUE);
    assign new_issue = merge(issue_word, pwdata, pstrb);
    assign opc = new_issue[fau_pkg::ISS_OPC_LSB +: 8];
    assign slot = new_issue[fau_pkg::ISS_SLOT_LSB +: 3];
    assign guard_present = new_issue[fau_pkg::ISS_GUARD_BIT];
    assign guard_ok = !guard_present || guard_word[0];
    assign slot_ok = (slot == fau_pkg::SLOT_A) || (slot == fau_pkg::SLOT_B);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issue_word <= 32'h0000_0000;
        end else if (issue_req) begin
            issue_word <= new_issue;
        end
    end

    // Absolute value datapath.
    always_comb begin
        abs_flags = '0;
        if (fau_pkg::is_denorm(src1)) begin
            abs_res = 32'h0000_0000;
            abs_flags[fau_pkg::FLG_IFZ] = 1'b1;
        end else if (fau_pkg::is_snan(src1)) begin
            abs_res = fau_pkg::QNAN;
            abs_flags[fau_pkg::FLG_INV] = 1'b1;
        end else if (fau_pkg::is_nan(src1)) begin
            // Quiet NaN keeps its payload and sign bit, matching pass-through.
            abs_res = src1;
        end else begin
            abs_res = {1'b0, src1[30:0]};
        end
    end

    fau_adder u_adder (
        .op_a(src1),
        .op_b(src2),
        .rmode(rmode_reg),
        .sum(add_sum),
        .flags(add_flags)
    );

    // Operation select.
    always_comb begin
        op_res = 32'h0000_0000;
        op_flags = '0;
        op_setflags = 1'b0;
        op_legal = slot_ok;
        unique case (opc)
            fau_pkg::OPC_ABS: begin
                op_res = abs_res;
                op_flags = abs_flags;
                op_setflags = 1'b1;
            end
            fau_pkg::OPC_ABS_FLAGS: begin
                op_res = {{(32 - FW){1'b0}}, abs_flags};
                op_setflags = 1'b0;
            end
            fau_pkg::OPC_ADD: begin
                op_res = add_sum;
                op_flags = add_flags;
                op_setflags = 1'b1;
            end
            default: begin
                op_legal = 1'b0;
            end
        endcase
    end

    // Fixed-latency pipeline; every operation retires LATENCY edges after issue unless its guard blocks it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_valid <= '0;
            pipe_wr <= '0;
            pipe_setflags <= '0;
        end else begin
            pipe_valid[0] <= issue_req && op_legal;
            pipe_wr[0] <= guard_ok;
            pipe_setflags[0] <= op_setflags;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_valid[i] <= pipe_valid[i-1];
                pipe_wr[i] <= pipe_wr[i-1];
                pipe_setflags[i] <= pipe_setflags[i-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_res[i] <= 32'h0000_0000;
                pipe_flags[i] <= '0;
            end
        end else begin
            pipe_res[0] <= op_res;
            pipe_flags[0] <= op_flags;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_res[i] <= pipe_res[i-1];
                pipe_flags[i] <= pipe_flags[i-1];
            end
        end
    end

    assign retire = pipe_valid[LATENCY-1] && pipe_wr[LATENCY-1];
    assign retire_flags = (retire && pipe_setflags[LATENCY-1]) ? pipe_flags[LATENCY-1] : '0;

    // Destination register and write strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest <= 32'h0000_0000;
            result_strobe <= 1'b0;
        end else begin
            result_strobe <= retire;
            if (retire) begin
                dest <= pipe_res[LATENCY-1];
            end else if (access_wr && (paddr == fau_pkg::ADDR_DEST)) begin
                dest <= merge(dest, pwdata, pstrb);
            end
        end
    end

    // Status word: a software write replaces the flags, but sets in the same cycle still win.
    assign sw_write = merge({22'h00_0000, rmode_reg, 1'b0, flag_reg}, pwdata, pstrb);

    always_comb begin
        next_flags = flag_reg;
        if (access_wr && (paddr == fau_pkg::ADDR_STATUS_WORD)) begin
            next_flags = sw_write[FW-1:0];
        end
        next_flags = next_flags | retire_flags | ext_flag_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= '0;
            rmode_reg <= 2'b00;
        end else begin
            flag_reg <= next_flags;
            if (access_wr && (paddr == fau_pkg::ADDR_STATUS_WORD)) begin
                rmode_reg <= sw_write[fau_pkg::SW_RM_LSB +: 2];
            end
        end
    end

    assign status_flags = flag_reg;

    // Rejected issues are sticky; writing one clears, a new rejection in that cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject <= 1'b0;
        end else if (issue_req && !op_legal) begin
            reject <= 1'b1;
        end else if (access_wr && (paddr == fau_pkg::ADDR_UNIT_STATUS) &&
                     pstrb[0] && pwdata[fau_pkg::US_REJECT_BIT]) begin
            reject <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/fau_monitor.sv */
// Concurrent checks on the float abs/add unit, seen only through its top-level ports.
// Assumes one pclk domain and asynchronous active-low presetn; attached by bind below.
`timescale 1ns/1ps
`default_nettype none
module fau_monitor #(
    parameter int LATENCY = 3
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fau_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Flags and results
    input wire logic [fau_pkg::FLAG_W-1:0] ext_flag_set,
    input wire logic [fau_pkg::FLAG_W-1:0] status_flags,
    input wire logic result_strobe
);
    logic iss_wr;
    logic sw_wr;
    assign iss_wr = psel && penable && pwrite && (paddr == fau_pkg::ADDR_ISSUE);
    assign sw_wr = psel && penable && pwrite && (paddr == fau_pkg::ADDR_STATUS_WORD);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A retire strobe must trace back to an issue exactly one cycle more than the pipeline depth earlier.
    strobe_cause_a: assert property (result_strobe |-> $past(iss_wr, LATENCY + 1))
        else $error("result strobe without matching issue");
    strobe_single_a: assert property (result_strobe |=> !result_strobe)
        else $error("result strobe longer than one cycle");
    sticky_flags_a: assert property (!sw_wr |=>
        ((status_flags & $past(status_flags)) == $past(status_flags)))
        else $error("status flag cleared without a status write");
    sw_clear_a: assert property (sw_wr && pstrb[0] ##1 !result_strobe |->
        ((status_flags & ~($past(pwdata[6:0]) | $past(ext_flag_set))) == '0))
        else $error("status write did not clear flags");
    ext_or_a: assert property ((ext_flag_set != '0) |=>
        ((status_flags & $past(ext_flag_set)) == $past(ext_flag_set)))
        else $error("external flag update lost");
    ext_exact_a: assert property ((ext_flag_set != '0) && !sw_wr ##1 !result_strobe |->
        (status_flags == ($past(status_flags) | $past(ext_flag_set))))
        else $error("external flag update not a plain OR");
    rise_cause_a: assert property (((status_flags & ~$past(status_flags)) != '0) |->
        (($past(ext_flag_set) != '0) || result_strobe || $past(sw_wr)))
        else $error("status flag set apart from a destination write");
    flags_hold_a: assert property (!sw_wr && (ext_flag_set == '0) ##1 !result_strobe |->
        $stable(status_flags))
        else $error("status flags moved with no write");

    cover property (result_strobe ##1 (status_flags != '0));
    cover property (sw_wr ##1 (status_flags == '0));
    cover property ((ext_flag_set != '0) ##1 result_strobe);
endmodule

bind fau_top fau_monitor #(.LATENCY(LATENCY)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_flag_set, .status_flags,
    .result_strobe);
`default_nettype wire

/* tb/fau_flag_src.sv */
// Model of another float unit that retires flag updates into the shared status word.
// Assumes the bench raises fire one cycle before the wanted retire edge.
`timescale 1ns/1ps
`default_nettype none
module fau_flag_src (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request from the bench
    input wire logic fire,
    input wire logic [fau_pkg::FLAG_W-1:0] bits,
    // Flags of the retiring unit
    output logic [fau_pkg::FLAG_W-1:0] ext_flag_set
);
    // The update lasts one cycle only, as a real unit retires once per operation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_set <= '0;
        end else begin
            ext_flag_set <= fire ? bits : '0;
        end
    end
endmodule
`default_nettype wire

/* tb/fau_top_tb.sv */
// Self-checking bench for the float abs/add unit driven over APB.
// Assumes fau_pkg, fau_top, the checker and the flag source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fau_top_tb;
    localparam logic [7:0] ABS = fau_pkg::OPC_ABS;
    localparam logic [7:0] ABF = fau_pkg::OPC_ABS_FLAGS;
    localparam logic [7:0] ADD = fau_pkg::OPC_ADD;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [fau_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [fau_pkg::FLAG_W-1:0] ext;
    logic [fau_pkg::FLAG_W-1:0] status_flags;
    logic result_strobe;
    logic fire = 1'b0;
    logic [fau_pkg::FLAG_W-1:0] fbits = '0;
    logic [2:0] slot = fau_pkg::SLOT_A;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    always #2.5 pclk = ~pclk;

    fau_top #(.LATENCY(fau_pkg::LATENCY)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_flag_set(ext), .status_flags,
        .result_strobe);
    fau_flag_src u_src (.pclk, .presetn, .fire, .bits(fbits), .ext_flag_set(ext));

    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One idle cycle before each setup keeps every signal to one assignment per time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // g is {guard present, guard LSB}; x is what the other unit retires with this op.
    task automatic op(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b,
        input logic [1:0] g, input logic [9:0] sw, input logic [6:0] x,
        input logic [31:0] exp_d, input logic [6:0] exp_f);
        logic [31:0] r;
        logic e;
        int n;
        wr(fau_pkg::ADDR_SRC1, a);
        wr(fau_pkg::ADDR_SRC2, b);
        wr(fau_pkg::ADDR_GUARD, {30'h0000_0000, g});
        wr(fau_pkg::ADDR_STATUS_WORD, {22'h00_0000, sw});
        slot = (slot == fau_pkg::SLOT_A) ? fau_pkg::SLOT_B : fau_pkg::SLOT_A;
        wr(fau_pkg::ADDR_ISSUE, {19'h0_0000, g[1], 1'b0, slot, opc});
        n = 1;
        @(posedge pclk);
        fire <= (x != '0);
        fbits <= x;
        do begin
            @(posedge pclk);
            n++;
            fire <= 1'b0;
            #1;
        end while (result_strobe !== 1'b1 && n < 8);
        chk(n, (g[1] && !g[0]) ? 8 : fau_pkg::LATENCY);
        apb(1'b0, fau_pkg::ADDR_DEST, '0, r, e);
        chk(r, exp_d);
        apb(1'b0, fau_pkg::ADDR_STATUS_WORD, '0, r, e);
        chk(r, {22'h00_0000, sw} | exp_f | x);
    endtask

    task automatic s_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, fau_pkg::ADDR_STATUS_WORD, '0, r, e);
        chk(r, '0);
        apb(1'b0, 8'h1c, '0, r, e);
        chk({r[30:0], e}, 32'h0000_0001);
        wr(fau_pkg::ADDR_ISSUE, {21'h00_0000, 3'h2, ADD});
        repeat (6) @(posedge pclk);
        apb(1'b0, fau_pkg::ADDR_UNIT_STATUS, '0, r, e);
        chk(r, 32'h0000_0002);
        wr(fau_pkg::ADDR_UNIT_STATUS, 32'h0000_0002);
        apb(1'b0, fau_pkg::ADDR_UNIT_STATUS, '0, r, e);
        chk(r, '0);
        pstrb <= 4'h1;
        wr(fau_pkg::ADDR_SRC1, 32'h1234_5678);
        pstrb <= 4'hf;
        apb(1'b0, fau_pkg::ADDR_SRC1, '0, r, e);
        chk(r, 32'h0000_0078);
        wr(fau_pkg::ADDR_ISSUE, {21'h00_0000, fau_pkg::SLOT_B, ABF});
        apb(1'b0, fau_pkg::ADDR_UNIT_STATUS, '0, r, e);
        chk(r, 32'h0000_0001);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        op(ABS, 32'hbf80_0000, '0, 2'h0, 10'h07f, '0, 32'h3f80_0000, '0);
        op(ABS, 32'h0040_0000, '0, 2'h0, '0, '0, '0, 7'h20);
        op(ABS, 32'hffbf_ffff, '0, 2'h0, '0, '0, 32'hffff_ffff, 7'h10);
        op(ABS, 32'hffff_ffff, '0, 2'h0, '0, '0, 32'hffff_ffff, '0);
        op(ABS, 32'hff7f_ffff, '0, 2'h3, '0, '0, 32'h7f7f_ffff, '0);
        op(ABS, 32'h0040_0000, '0, 2'h2, '0, '0, 32'h7f7f_ffff, '0);
        op(ABF, 32'h0040_0000, '0, 2'h0, '0, '0, 32'h0000_0020, '0);
        op(ABF, 32'hffbf_ffff, '0, 2'h3, 10'h001, '0, 32'h0000_0010, '0);
        op(ABF, 32'h0040_0000, '0, 2'h2, '0, '0, 32'h0000_0010, '0);
        op(ADD, 32'hc040_0000, 32'h3f80_0000, 2'h0, '0, '0, 32'hc000_0000, '0);
        op(ADD, 32'h4040_0000, 32'h0080_0000, 2'h0, '0, '0, 32'h4040_0000, 7'h02);
        op(ADD, 32'h4040_0000, 32'h0080_0000, 2'h0, 10'h100, '0, 32'h4040_0000, 7'h02);
        op(ADD, 32'h4040_0000, 32'h0080_0000, 2'h0, 10'h200, '0, 32'h4040_0001, 7'h02);
        op(ADD, 32'hc040_0000, 32'h8080_0000, 2'h0, 10'h300, '0, 32'hc040_0001, 7'h02);
        op(ADD, 32'h4040_0000, 32'h0040_0000, 2'h0, '0, '0, 32'h4040_0000, 7'h20);
        op(ADD, 32'h00c0_0000, 32'h8080_0000, 2'h0, '0, '0, '0, 7'h46);
        op(ADD, 32'h7f80_0000, 32'hff80_0000, 2'h0, '0, 7'h01, 32'hffff_ffff, 7'h10);
        op(ADD, 32'h7f7f_ffff, 32'h7f7f_ffff, 2'h0, '0, '0, 32'h7f80_0000, 7'h0a);
        op(ADD, 32'h4040_0000, 32'h0040_0000, 2'h2, '0, '0, 32'h7f80_0000, '0);
        results();
    end
endmodule
`default_nettype wire
